// file: inc/ctimer_pkg.sv
package ctimer_pkg;
   localparam int CW = 8;
   localparam logic [CW-1:0] ZERO_CNT = 8'h00;
   localparam logic [CW-1:0] ONE_CNT = 8'h01;
   // carrier output control register fields
   localparam int COC_REMOTE_BIT = 2;
   localparam int COC_GBUF_BIT = 1;
   localparam int COC_GATE_BIT = 0;
   localparam logic [CW-1:0] COC_RESET = 8'h00;
   localparam logic [CW-1:0] COC_USED_MASK = 8'h07;

   typedef enum logic [1:0] {
      MODE_INTERVAL = 2'b00,
      MODE_SQUARE = 2'b01,
      MODE_PWM = 2'b11,
      MODE_CARRIER = 2'b10
   } mode_e;

   // configuration and compare values written by software
   typedef struct packed {
      mode_e mode;
      logic ext_clk;
      logic upper_count_enable;
      logic lower_count_enable;
      logic output_enable_bit;
      logic [CW-1:0] upper_compare;
      logic [CW-1:0] low_compare;
      logic [CW-1:0] high_compare;
   } cfg_s;

   // match events and count values
   typedef struct packed {
      logic upper_match_irq;
      logic lower_match_irq;
      logic [CW-1:0] upper_counter;
      logic [CW-1:0] lower_counter;
   } stat_s;
endpackage

// file: src/ctimer.sv
`timescale 1ns/10ps
// Overview of operation
// - cascaded event counting adds one per valid event pin edge
// - cascaded double match clears both counters, raises lower irq only
// - lower-only match in cascade neither clears nor interrupts
// - cascade start and clear follow lower enable only
// - upper counter is high byte, lower counter low byte
// - cascaded square mode toggles output on each double match
// - clearing lower enable forces square output to zero
// - output starts low when output enable is set
// - low compare match raises lower irq, toggles, selects high compare
// - high compare match raises lower irq, toggles, selects low compare
// - upper match raises upper irq; its rising edge loads gate from buffer
// - carrier passes to output pin only while gate is one
// - control register: bit2 remote select, bit1 gate buffer, bit0 gate
// - gate writes accepted only while output enable is zero
// - gate buffer is lost when carrier is stopped
// - carrier mode runs lower counter under its own enable, upper counter only with both enables
// - pwm low width from low compare, high width from high compare
// - pwm low compare match clears lower counter
// - pwm high compare match clears lower counter
module ctimer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire ctimer_pkg::cfg_s cfg_i,
   input wire logic event_input_pin_i,
   input wire logic coc_wr_i,
   input wire logic [ctimer_pkg::CW-1:0] coc_wdata_i,
   output logic [ctimer_pkg::CW-1:0] coc_rdata_o,
   output ctimer_pkg::stat_s stat_o,
   output logic timer_output_pin_o
);
   import ctimer_pkg::*;

   logic [2:0] ev_sync_r;
   logic ev_level_r;
   logic ev_rise;
   logic tick;
   logic cascade;
   logic carrier;
   logic pwm;
   logic [CW-1:0] lower_counter_r;
   logic [CW-1:0] upper_counter_r;
   logic use_high_r;
   logic out_r;
   logic oe_prev_r;
   logic lower_en_prev_r;
   logic carrier_run_prev_r;
   logic lower_match_irq_r;
   logic upper_match_irq_r;
   logic upper_irq_prev_r;
   logic remote_r;
   logic gbuf_r;
   logic gate_r;
   logic [CW-1:0] lo_cmp;
   logic lo_hit;
   logic up_hit;
   logic both_hit;
   logic carrier_run;
   logic oe_rise;
   logic reload;
   logic [2*CW-1:0] count16;

   // event pin: three stages, edge counted once stages 2 and 3 agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_sync_r <= 3'b000;
      end else begin
         ev_sync_r <= {ev_sync_r[1:0], event_input_pin_i};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_level_r <= 1'b0;
      end else if (ev_sync_r[1] == ev_sync_r[2]) begin
         ev_level_r <= ev_sync_r[2];
      end
   end

   assign ev_rise = (ev_sync_r[1] == ev_sync_r[2]) && ev_sync_r[2] && !ev_level_r;
   assign tick = cfg_i.ext_clk ? ev_rise : 1'b1;
   assign cascade = (cfg_i.mode == MODE_INTERVAL) || (cfg_i.mode == MODE_SQUARE);
   assign carrier = (cfg_i.mode == MODE_CARRIER);
   assign pwm = (cfg_i.mode == MODE_PWM);
   assign carrier_run = carrier && cfg_i.lower_count_enable && cfg_i.upper_count_enable;
   assign lo_cmp = (use_high_r && !cascade) ? cfg_i.high_compare : cfg_i.low_compare;
   assign lo_hit = (lower_counter_r == lo_cmp);
   assign up_hit = (upper_counter_r == cfg_i.upper_compare);
   assign both_hit = lo_hit && up_hit;
   assign oe_rise = cfg_i.output_enable_bit && !oe_prev_r;
   assign reload = upper_match_irq_r && !upper_irq_prev_r;
   assign count16 = {upper_counter_r, lower_counter_r};

   // lower counter: low byte in cascade, carrier/pwm base otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lower_counter_r <= ZERO_CNT;
      end else if (!cfg_i.lower_count_enable) begin
         lower_counter_r <= ZERO_CNT;
      end else if (tick) begin
         if (cascade && both_hit) begin
            lower_counter_r <= ZERO_CNT;
         end else if (!cascade && lo_hit) begin
            lower_counter_r <= ZERO_CNT;
         end else begin
            lower_counter_r <= lower_counter_r + ONE_CNT;
         end
      end
   end

   // upper counter: carries from lower in cascade, free in carrier
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upper_counter_r <= ZERO_CNT;
      end else if (cascade) begin
         if (!cfg_i.lower_count_enable) begin
            upper_counter_r <= ZERO_CNT;
         end else if (tick && both_hit) begin
            upper_counter_r <= ZERO_CNT;
         end else if (tick && lower_counter_r == '1) begin
            upper_counter_r <= upper_counter_r + ONE_CNT;
         end
      end else if (!carrier_run) begin
         upper_counter_r <= ZERO_CNT;
      end else if (up_hit) begin
         upper_counter_r <= ZERO_CNT;
      end else begin
         upper_counter_r <= upper_counter_r + ONE_CNT;
      end
   end

   // compare select alternates low/high outside cascade
   // enabling the pin restarts on the low phase, so pin level and select stay in step
   always_ff @(posedge clk_i) begin
      if (rst_i || !cfg_i.lower_count_enable || cascade) begin
         use_high_r <= 1'b0;
      end else if (oe_rise) begin
         use_high_r <= 1'b0;
      end else if (tick && lo_hit) begin
         use_high_r <= !use_high_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lower_match_irq_r <= 1'b0;
      end else begin
         lower_match_irq_r <= cfg_i.lower_count_enable && tick && (cascade ? both_hit : lo_hit);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upper_match_irq_r <= 1'b0;
         upper_irq_prev_r <= 1'b0;
      end else begin
         upper_match_irq_r <= carrier_run && up_hit;
         upper_irq_prev_r <= upper_match_irq_r;
      end
   end

   // timer output flip: low on enable rise and while stopped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_r <= 1'b0;
         oe_prev_r <= 1'b0;
         lower_en_prev_r <= 1'b0;
      end else begin
         oe_prev_r <= cfg_i.output_enable_bit;
         lower_en_prev_r <= cfg_i.lower_count_enable;
         if (cfg_i.output_enable_bit && !oe_prev_r) begin
            out_r <= 1'b0;
         end else if (!cfg_i.lower_count_enable) begin
            out_r <= 1'b0;
         end else if (cfg_i.lower_count_enable && tick && (cascade ? both_hit : lo_hit)) begin
            if (cfg_i.mode != MODE_INTERVAL) begin
               out_r <= !out_r;
            end
         end
      end
   end

   // control register; stopping the carrier drops the buffer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         remote_r <= 1'b0;
         gbuf_r <= 1'b0;
         carrier_run_prev_r <= 1'b0;
      end else begin
         carrier_run_prev_r <= carrier_run;
         if (coc_wr_i) begin
            remote_r <= coc_wdata_i[COC_REMOTE_BIT];
            gbuf_r <= coc_wdata_i[COC_GBUF_BIT];
         end else if (carrier_run_prev_r && !carrier_run) begin
            gbuf_r <= 1'b0;
         end
      end
   end

   // gate: reload on irq rising edge wins over a software write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_r <= 1'b0;
      end else if (upper_match_irq_r && !upper_irq_prev_r) begin
         gate_r <= gbuf_r;
      end else if (coc_wr_i && !cfg_i.output_enable_bit) begin
         gate_r <= coc_wdata_i[COC_GATE_BIT];
      end
   end

   always_comb begin
      coc_rdata_o = COC_RESET;
      coc_rdata_o[COC_REMOTE_BIT] = remote_r;
      coc_rdata_o[COC_GBUF_BIT] = gbuf_r;
      coc_rdata_o[COC_GATE_BIT] = gate_r;
   end

   assign stat_o = '{upper_match_irq: upper_match_irq_r, lower_match_irq: lower_match_irq_r,
                     upper_counter: upper_counter_r, lower_counter: lower_counter_r};

   // remote select one is treated as gate level output (no carrier)
   always_comb begin
      timer_output_pin_o = 1'b0;
      if (cfg_i.output_enable_bit) begin
         if (carrier) begin
            timer_output_pin_o = gate_r && (remote_r || out_r);
         end else begin
            timer_output_pin_o = out_r;
         end
      end
   end

   double_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cascade && cfg_i.lower_count_enable && tick && both_hit |=> lower_counter_r == ZERO_CNT
      && upper_counter_r == ZERO_CNT && lower_match_irq_r && !upper_match_irq_r)
      else $error("cascade double match did not clear");
   lower_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cascade && cfg_i.lower_count_enable && tick && lo_hit && !up_hit |=> !lower_match_irq_r)
      else $error("irq on lower-only match");
   stop_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cascade && !cfg_i.lower_count_enable |=> lower_counter_r == ZERO_CNT && upper_counter_r == ZERO_CNT)
      else $error("cascade not cleared by lower enable");
   square_flip_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_i.mode == MODE_SQUARE && $stable(cfg_i) && cfg_i.output_enable_bit && oe_prev_r
      && cfg_i.lower_count_enable && tick && both_hit |=> out_r != $past(out_r))
      else $error("square output did not toggle");
   stop_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg_i.lower_count_enable |=> !out_r)
      else $error("output not forced low");
   enable_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(cfg_i.output_enable_bit) |=> !out_r)
      else $error("output not low at enable");
   select_swap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cascade && $stable(cfg_i) && cfg_i.lower_count_enable && tick && lo_hit |=> use_high_r != $past(use_high_r)
      && lower_match_irq_r)
      else $error("compare select did not swap");
   gate_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
      upper_match_irq_r && !upper_irq_prev_r |=> gate_r == $past(gbuf_r))
      else $error("gate not reloaded");
   gate_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      carrier && !gate_r |-> !timer_output_pin_o)
      else $error("carrier leaked with gate low");
   gate_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
      coc_wr_i && cfg_i.output_enable_bit && !(upper_match_irq_r && !upper_irq_prev_r) |=> $stable(gate_r))
      else $error("gate written while output enabled");
   pwm_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pwm && cfg_i.lower_count_enable && tick && lo_hit |=> lower_counter_r == ZERO_CNT)
      else $error("pwm counter not cleared");

   // cascade counting checks
   count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cascade && cfg_i.lower_count_enable && tick && !both_hit |=> count16 == 16'($past(count16) + 16'h0001))
      else $error("cascade count did not step by one");
   event_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cascade && cfg_i.ext_clk && cfg_i.lower_count_enable && !ev_rise |=> $stable(count16))
      else $error("cascade count moved without an event edge");
   cascade_no_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cascade |=> !upper_match_irq_r)
      else $error("upper irq raised in cascade");
   irq_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(cascade) && lower_match_irq_r |-> count16 == '0)
      else $error("cascade irq without cleared counters");
   interval_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_i.mode == MODE_INTERVAL && !out_r |=> !out_r)
      else $error("interval mode moved the output");

   // pwm and carrier checks
   out_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cascade && $stable(cfg_i) && oe_prev_r && cfg_i.lower_count_enable && tick && lo_hit
      |=> out_r != $past(out_r))
      else $error("compare match did not toggle output");
   pwm_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cascade && $stable(cfg_i) && oe_prev_r && cfg_i.lower_count_enable && tick && lo_hit
      |=> out_r == !$past(use_high_r))
      else $error("output level out of step with compare select");
   pwm_high_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pwm && cfg_i.lower_count_enable && tick && lo_hit && use_high_r |=> lower_counter_r == ZERO_CNT)
      else $error("pwm high match did not clear");
   carrier_split_a: assert property (@(posedge clk_i) disable iff (rst_i)
      carrier && !carrier_run |=> upper_counter_r == ZERO_CNT)
      else $error("upper counter ran without both enables");
   lower_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cascade && !cfg_i.lower_count_enable |=> lower_counter_r == ZERO_CNT)
      else $error("lower counter ran without its enable");
   gate_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
      carrier && cfg_i.output_enable_bit && gate_r && !remote_r |-> timer_output_pin_o == out_r)
      else $error("carrier not passed with gate high");
   remote_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      carrier && cfg_i.output_enable_bit && remote_r |-> timer_output_pin_o == gate_r)
      else $error("remote select did not give gate level");

   // control register checks
   coc_field_a: assert property (@(posedge clk_i) disable iff (rst_i)
      coc_wr_i |=> coc_rdata_o[COC_REMOTE_BIT] == $past(coc_wdata_i[COC_REMOTE_BIT])
      && coc_rdata_o[COC_GBUF_BIT] == $past(coc_wdata_i[COC_GBUF_BIT]))
      else $error("control register write lost");
   gate_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      coc_wr_i && !cfg_i.output_enable_bit && !reload |=> gate_r == $past(coc_wdata_i[COC_GATE_BIT]))
      else $error("gate write refused while output off");
   gate_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !coc_wr_i && !reload |=> $stable(gate_r))
      else $error("gate changed without write or reload");
   gbuf_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      carrier_run_prev_r && !carrier_run && !coc_wr_i |=> !gbuf_r)
      else $error("gate buffer kept over a stop");
   reset_state_a: assert property (@(posedge clk_i)
      rst_i |=> stat_o == '0 && coc_rdata_o == COC_RESET && !timer_output_pin_o)
      else $error("state not cleared by reset");
   pin_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg_i.output_enable_bit |-> !timer_output_pin_o)
      else $error("output pin driven while disabled");
   cover_cascade_c: cover property (@(posedge clk_i) cascade && lower_match_irq_r);
   cover_pwm_c: cover property (@(posedge clk_i) pwm && use_high_r && lower_match_irq_r);
   cover_carrier_c: cover property (@(posedge clk_i) carrier && gate_r && timer_output_pin_o);
   cover_event_c: cover property (@(posedge clk_i) cascade && cfg_i.ext_clk && ev_rise);
   cover_reload_c: cover property (@(posedge clk_i) reload && gbuf_r);
endmodule

// file: tb/ev_src.sv
`timescale 1ns/10ps
module ev_src (
   input wire logic clk_i,
   output logic pin_o
);
   // idles low, so starting a count never sees a stray edge
   initial pin_o = 1'b0;
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (3) @(posedge clk_i);
         pin_o <= 1'b1;
         repeat (3) @(posedge clk_i);
         pin_o <= 1'b0;
      end
      repeat (6) @(posedge clk_i);
   endtask
endmodule

// file: tb/tb_ctimer.sv
`timescale 1ns/10ps
module tb_ctimer;
   import ctimer_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   cfg_s cfg = '0;
   logic ev;
   logic wr = 1'b0;
   logic [CW-1:0] wd = ZERO_CNT;
   logic [CW-1:0] rd;
   stat_s st;
   logic timer_output_pin;
   int miscompares = 0;
   int check_count = 0;
   int cyc = 0;
   int up_n = 0;
   int n, m, a, b;
   ctimer dut_u (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .event_input_pin_i(ev), .coc_wr_i(wr),
      .coc_wdata_i(wd), .coc_rdata_o(rd), .stat_o(st), .timer_output_pin_o(timer_output_pin));
   ev_src ev_u (.clk_i(clk_i), .pin_o(ev));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   task automatic finish_test();
      if (miscompares == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (st.upper_match_irq === 1'b1) begin
         up_n <= up_n + 1;
      end
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic chk(input logic ok, input string s);
      check_count++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("ERROR %0t %s", $time, s);
      end
   endtask
   // expected widths and periods follow from the compare values alone
   function automatic int phase_len(input int cmp);
      return cmp + 1;
   endfunction
   function automatic int cascade_len(input int up, input int lo);
      return 256 * up + lo + 1;
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   task automatic setup(input mode_e md, input logic x, input logic [CW-1:0] u, l, h);
      @(posedge clk_i);
      cfg.output_enable_bit <= 1'b0;
      cfg.upper_count_enable <= 1'b0;
      cfg.lower_count_enable <= 1'b0;
      @(posedge clk_i);
      cfg <= '{md, x, 1'b0, 1'b0, 1'b0, u, l, h};
      tick(2);
   endtask
   task automatic go(input logic oe, input logic up);
      @(posedge clk_i);
      cfg.output_enable_bit <= oe;
      cfg.upper_count_enable <= up;
      cfg.lower_count_enable <= 1'b1;
   endtask
   task automatic wcoc(input logic [CW-1:0] v);
      @(posedge clk_i);
      wr <= 1'b1;
      wd <= v;
      @(posedge clk_i);
      wr <= 1'b0;
      #1;
   endtask
   task automatic nxt_irq(output int g);
      g = 0;
      do begin
         @(posedge clk_i);
         #1;
         g++;
      end while (st.lower_match_irq !== 1'b1 && g < 2000);
   endtask
   // bounded so a stuck pin cannot hang the run
   task automatic wid(input logic lv, output int g);
      g = 0;
      while (timer_output_pin !== lv && g < 3000) begin
         @(posedge clk_i);
         #1;
         g++;
      end
      g = 0;
      while (timer_output_pin === lv && g < 3000) begin
         @(posedge clk_i);
         #1;
         g++;
      end
   endtask
   initial begin
      n = $urandom(43062);
      tick(5);
      rst_i <= 1'b0;
      tick(1);
      #1;
      chk(rd === COC_RESET && timer_output_pin === 1'b0 && st === '0, "reset");
      n = $urandom_range(300, 250);
      setup(MODE_INTERVAL, 1'b1, 8'hFF, 8'hFF, 8'hFF);
      go(1'b0, 1'b0);
      ev_u.pulses(n);
      #1;
      chk({st.upper_counter, st.lower_counter} === n[15:0], "event count");
      setup(MODE_INTERVAL, 1'b0, ONE_CNT, 8'h05, 8'hFF);
      go(1'b0, 1'b1);
      nxt_irq(a);
      nxt_irq(a);
      chk(a === cascade_len(ONE_CNT, 8'h05) && {st.upper_counter, st.lower_counter} === 16'h0000, "cascade period");
      m = $urandom_range(9, 2);
      setup(MODE_SQUARE, 1'b0, ZERO_CNT, m[7:0], 8'hFF);
      @(posedge clk_i);
      cfg.output_enable_bit <= 1'b1;
      tick(2);
      #1;
      chk(timer_output_pin === 1'b0, "initial low");
      go(1'b1, 1'b0);
      wid(1'b1, a);
      wid(1'b0, b);
      chk(a === phase_len(m) && b === phase_len(m), "square width");
      @(posedge clk_i);
      cfg.lower_count_enable <= 1'b0;
      tick(2);
      #1;
      chk(timer_output_pin === 1'b0 && st.lower_counter === ZERO_CNT, "stop clears");
      chk(up_n === 0, "upper irq");
      // second pass is the zero compare corner
      for (int i = 0; i < 2; i++) begin
         m = i ? 0 : $urandom_range(9, 1);
         n = i ? 0 : $urandom_range(9, 1);
         setup(MODE_PWM, 1'b0, ZERO_CNT, m[7:0], n[7:0]);
         go(1'b1, 1'b0);
         wid(1'b1, a);
         wid(1'b0, b);
         chk(a === phase_len(n) && b === phase_len(m), "pwm widths");
      end
      setup(MODE_CARRIER, 1'b0, 8'h0F, 8'h02, 8'h02);
      m = $urandom;
      wcoc(m[7:0]);
      chk(rd === (m[7:0] & COC_USED_MASK), "coc readback");
      wcoc(8'h03);
      @(posedge clk_i);
      cfg.output_enable_bit <= 1'b1;
      wcoc(8'h02);
      chk(rd === 8'h03, "gate locked");
      @(posedge clk_i);
      cfg.output_enable_bit <= 1'b0;
      wcoc(8'h02);
      go(1'b1, 1'b1);
      a = 0;
      repeat (12) begin
         @(posedge clk_i);
         #1;
         if (timer_output_pin !== 1'b0) a++;
      end
      chk(a === 0, "gate low holds");
      b = 0;
      while (rd[COC_GATE_BIT] !== 1'b1 && b < 60) begin
         @(posedge clk_i);
         #1;
         b++;
      end
      chk(rd[COC_GATE_BIT] === 1'b1 && up_n > 0, "gate reload");
      wid(1'b1, a);
      chk(a > 0 && a < 3000, "carrier out");
      wid(1'b1, a);
      chk(a === phase_len(8'h02), "carrier high width");
      setup(MODE_CARRIER, 1'b0, 8'h0F, 8'h02, 8'h02);
      #1;
      chk(rd[COC_GBUF_BIT] === 1'b0, "buffer lost");
      finish_test();
   end
endmodule
